//--- rtl/xod_pkg.sv
// Shared constants and types for the extended opcode decoder.
package xod_pkg;
  // Primary opcodes.
  localparam logic [5:0] PO_FUSED = 6'h01;
  localparam logic [5:0] PO_VD_LD = 6'h05;
  localparam logic [5:0] PO_VD_ST = 6'h06;
  localparam logic [5:0] PO_MUL_IMM = 6'h07;
  localparam logic [5:0] PO_VD_LDU = 6'h09;
  localparam logic [5:0] PO_VD_STU = 6'h16;
  localparam logic [5:0] PO_ROT64 = 6'h1E;
  localparam logic [5:0] PO_XFORM = 6'h1F;
  localparam logic [5:0] PO_STK_POP = 6'h3A;
  localparam logic [5:0] PO_STK_PUSH = 6'h3E;
  // Extended opcodes under the X-form primary.
  localparam logic [9:0] XO_DC_QUERY = 10'h196;
  localparam logic [9:0] XO_VD_LDX = 10'h011;
  localparam logic [9:0] XO_VD_STX = 10'h091;
  localparam logic [9:0] XO_SHL_VD = 10'h03B;
  localparam logic [9:0] XO_SHR_VD = 10'h23B;
  localparam logic [8:0] XO_MUL_REG = 9'h0EB;
  // Sub-opcodes of the 64-bit rotate primary.
  localparam logic [2:0] MD_CLR_LEFT = 3'h0;
  localparam logic [2:0] MD_CLR_RIGHT = 3'h1;
  localparam logic [2:0] MD_INSERT = 3'h3;
  // Stack frame format.
  localparam logic [1:0] DD_XO = 2'h3;
  localparam logic [3:0] CTX_ACCESSES = 4'hA;
  // Fused compare-branch kinds and bit sub-kinds.
  localparam logic [1:0] FC_SIGNED = 2'h0;
  localparam logic [1:0] FC_UNSIGNED = 2'h1;
  localparam logic [1:0] FC_IMM = 2'h2;
  localparam logic [1:0] FC_BIT = 2'h3;
  // Register map, byte addresses.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_COUNT = 12'h004;
  localparam logic [11:0] REG_LAST_ILL = 12'h008;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CNT_W = 16;

  typedef enum logic [4:0] {
    OP_NONE, OP_MUL_IMM, OP_MUL_REG, OP_ROT_CL, OP_ROT_CR, OP_ROT_INS,
    OP_VD_LD, OP_VD_LDU, OP_VD_ST, OP_VD_STU, OP_VD_LDX, OP_VD_STX,
    OP_DC_QUERY, OP_CB_SIGNED, OP_CB_UNSIGNED, OP_CB_IMM, OP_CB_BIT,
    OP_CB_CLRBIT, OP_STK_POP, OP_STK_PUSH, OP_SHL_VD, OP_SHR_VD
  } xod_op_t;

  typedef struct packed {
    xod_op_t op;
    logic illegal;
    logic [4:0] rt;
    logic [4:0] ra;
    logic [4:0] rb;
    logic [31:0] imm;
    logic [31:0] target;
    logic branch_polarity;
    logic [1:0] cond_bit_select;
    logic bit_from_reg;
    logic [31:0] bit_mask;
    logic link;
    logic two_step;
    logic shamt_word;
    logic sp_writeback;
    logic context_save_select;
    logic [3:0] acc_cnt;
  } xod_dec_t;
endpackage

//--- rtl/xod_decoder.sv
// Decoder for the architecture-specific and extended-variant instructions.
//
// Functional notes
// - Extended variant decodes immediate and register low-word 32-bit multiplies.
// - Extended variant decodes rotate insert, clear-right, clear-left; others undecoded.
// - Doubleword accesses use base plus 16-bit displacement, any alignment.
// - Displacement doubleword primaries: load 5, update 9, store 6, update 22.
// - Under primary 31: 406 cache query, 17 indexed load, 145 indexed store.
// - Primary 1 decodes five fused compare-and-branch kinds.
// - Bit kinds take bit number from immediate or register; test is non-destructive.
// - Fused compare-branch may take as long as compare plus branch.
// - Extended: 58/3 pop, 62/3 push, 31/59 shift left, 31/571 shift right.
// - Doubleword shifts take their amount from a single word register.
// - Push and pop move a fixed register frame and write back stack pointer.
// - Instructions are words; addresses are always word-aligned.
// - Primary opcode always sits in big-endian bits 0 to 5.
// - Wrong defined field or unsupported variable value raises illegal instruction.
// - Reserved bits are ignored and never cause illegal instruction.
// - Polarity bit picks branch on condition set or clear.
// - Fused extended opcode picks compare kind; bit numbers are big-endian.
// - Target is signed 10-bit word field shifted two; bit 31 is link.
// - Stack format extended opcode in bits 30-31 must be 3.
// - Stack format data and base registers must name the same register.
// - Stack displacement is 13-bit field, three zeros appended, sign-extended.
// - Context bit set gives ten accesses; clear gives zero, one or two.
// - A register field naming an undefined register raises illegal.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module xod_decoder
  import xod_pkg::*;
#(
  parameter bit EXT_VARIANT = 1'b1,
  parameter logic [31:0] GPR_DEFINED = 32'hFFFF_FFFF,
  parameter int CMP_CYCLES = 1,
  parameter int BR_CYCLES = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Instruction words from fetch.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_instr,
  input wire logic [31:0] in_pc,
  // Decoded operation towards execute.
  output logic out_valid,
  input wire logic out_ready,
  output xod_dec_t out_dec,
  output logic [3:0] out_cycles,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // The cycle budget of a fused branch must fit the four-bit output.
  if (CMP_CYCLES < 1 || BR_CYCLES < 1 || CMP_CYCLES + BR_CYCLES > 15) begin : g_bad_budget
    $error("xod_decoder: cycle budget out of range");
  end

  // Big-endian bit n of the word is in_instr[31-n].
  wire logic [5:0] f_po = in_instr[31:26];
  wire logic [4:0] f_rt = in_instr[25:21];
  wire logic [4:0] f_ra = in_instr[20:16];
  wire logic [4:0] f_rb = in_instr[15:11];
  wire logic [9:0] f_xo = in_instr[10:1];
  wire logic [8:0] f_xo9 = in_instr[9:1];
  wire logic [2:0] f_md = in_instr[4:2];
  wire logic [1:0] fused_cmp_ext_opcode = in_instr[25:24];
  wire logic branch_polarity = in_instr[23];
  wire logic [1:0] cond_bit_select = in_instr[22:21];
  wire logic [4:0] bit_number_imm = in_instr[15:11];
  wire logic [9:0] short_branch_disp = in_instr[10:1];
  wire logic [12:0] stack_disp_field = in_instr[15:3];
  wire logic context_save_select = in_instr[2];
  wire logic [1:0] f_dd_xo = in_instr[1:0];

  // Control register state and handshake.
  logic ext_en;
  logic in_fire;
  assign in_ready = !out_valid || out_ready;
  assign in_fire = in_valid && in_ready;

  // Immediate forms. Doubleword displacement carries no alignment check.
  wire logic [31:0] si_sext = {{16{in_instr[15]}}, in_instr[15:0]};
  wire logic [31:0] dd_sext = {{16{stack_disp_field[12]}}, stack_disp_field, 3'h0};
  wire logic [31:0] bd_sext = {{20{short_branch_disp[9]}}, short_branch_disp, 2'h0};
  // Fetch addresses are words, so the low two bits are dropped outright.
  wire logic [31:0] pc_word = {in_pc[31:2], 2'h0};
  wire logic [31:0] br_target = pc_word + bd_sext;
  // Big-endian bit number n names the little-endian bit 31-n.
  wire logic [31:0] bit_mask_imm = 32'h8000_0000 >> bit_number_imm;
  wire logic dd_small = (stack_disp_field == 13'h0001) || (stack_disp_field == 13'h1FFF);
  wire logic [3:0] stk_cnt = context_save_select ? CTX_ACCESSES :
    (stack_disp_field == 13'h0000) ? 4'h0 : dd_small ? 4'h1 : 4'h2;
  wire logic [3:0] fused_cycles = 4'(CMP_CYCLES + BR_CYCLES);

  // Operation select. Reserved bits are never examined.
  xod_op_t next_op;
  logic bad_field;
  logic ext_op;
  always_comb begin
    next_op = OP_NONE;
    bad_field = 1'b0;
    ext_op = 1'b0;
    case (f_po)
      PO_FUSED: begin
        case (fused_cmp_ext_opcode)
          FC_SIGNED: next_op = OP_CB_SIGNED;
          FC_UNSIGNED: next_op = OP_CB_UNSIGNED;
          FC_IMM: next_op = OP_CB_IMM;
          default: next_op = cond_bit_select[1] ? OP_CB_CLRBIT : OP_CB_BIT;
        endcase
      end
      PO_VD_LD: next_op = OP_VD_LD;
      PO_VD_LDU: next_op = OP_VD_LDU;
      PO_VD_ST: next_op = OP_VD_ST;
      PO_VD_STU: next_op = OP_VD_STU;
      PO_MUL_IMM: begin
        next_op = OP_MUL_IMM;
        ext_op = 1'b1;
      end
      PO_ROT64: begin
        ext_op = 1'b1;
        case (f_md)
          MD_CLR_LEFT: next_op = OP_ROT_CL;
          MD_CLR_RIGHT: next_op = OP_ROT_CR;
          MD_INSERT: next_op = OP_ROT_INS;
          default: bad_field = 1'b1;
        endcase
      end
      PO_XFORM: begin
        if (f_xo == XO_DC_QUERY) begin
          next_op = OP_DC_QUERY;
        end else if (f_xo == XO_VD_LDX) begin
          next_op = OP_VD_LDX;
        end else if (f_xo == XO_VD_STX) begin
          next_op = OP_VD_STX;
        end else if (f_xo == XO_SHL_VD) begin
          next_op = OP_SHL_VD;
          ext_op = 1'b1;
        end else if (f_xo == XO_SHR_VD) begin
          next_op = OP_SHR_VD;
          ext_op = 1'b1;
        end else if (f_xo9 == XO_MUL_REG) begin
          next_op = OP_MUL_REG;
          ext_op = 1'b1;
        end
      end
      PO_STK_POP, PO_STK_PUSH: begin
        ext_op = 1'b1;
        next_op = (f_po == PO_STK_POP) ? OP_STK_POP : OP_STK_PUSH;
        bad_field = (f_dd_xo != DD_XO) || (f_rt != f_ra);
      end
      default: next_op = OP_NONE;
    endcase
  end

  // Which register fields the operation really names.
  wire logic is_cb = next_op inside {OP_CB_SIGNED, OP_CB_UNSIGNED, OP_CB_IMM, OP_CB_BIT,
    OP_CB_CLRBIT};
  wire logic is_stk = next_op inside {OP_STK_POP, OP_STK_PUSH};
  wire logic is_rot = next_op inside {OP_ROT_CL, OP_ROT_CR, OP_ROT_INS};
  wire logic cb_rb_reg = next_op inside {OP_CB_SIGNED, OP_CB_UNSIGNED} ||
    ((next_op inside {OP_CB_BIT, OP_CB_CLRBIT}) && !cond_bit_select[0]);
  wire logic uses_rt = (next_op != OP_NONE) && !is_cb;
  wire logic uses_rb = cb_rb_reg || (next_op inside {OP_MUL_REG, OP_VD_LDX, OP_VD_STX,
    OP_DC_QUERY, OP_SHL_VD, OP_SHR_VD});
  wire logic bad_reg = (next_op != OP_NONE) && (!GPR_DEFINED[f_ra] ||
    (uses_rt && !GPR_DEFINED[f_rt]) || (uses_rb && !GPR_DEFINED[f_rb]));
  // Extended-only opcodes trap on the base variant so software may emulate them.
  wire logic next_ill = (ext_op && !ext_en) || bad_field || bad_reg;
  wire logic next_claim = (next_op != OP_NONE) || next_ill;

  // Decoded word assembled from the fields.
  xod_dec_t next_dec;
  always_comb begin
    next_dec = '0;
    next_dec.op = next_ill ? OP_NONE : next_op;
    next_dec.illegal = next_ill;
    next_dec.rt = f_rt;
    next_dec.ra = f_ra;
    next_dec.rb = f_rb;
    next_dec.imm = is_stk ? dd_sext : si_sext;
    next_dec.target = is_cb ? br_target : 32'h0000_0000;
    next_dec.branch_polarity = branch_polarity;
    next_dec.cond_bit_select = cond_bit_select;
    next_dec.bit_from_reg = cb_rb_reg;
    next_dec.bit_mask = bit_mask_imm;
    next_dec.link = is_cb && in_instr[0];
    next_dec.two_step = is_cb;
    next_dec.shamt_word = next_op inside {OP_SHL_VD, OP_SHR_VD};
    next_dec.sp_writeback = is_stk;
    next_dec.context_save_select = is_stk && context_save_select;
    next_dec.acc_cnt = is_stk ? stk_cnt : 4'h0;
    if (is_rot) begin
      next_dec.rb = 5'h00;
    end
  end

  // Output stage holds its word while execute stalls.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_dec <= '0;
      out_cycles <= 4'h0;
    end else if (in_ready) begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_dec <= next_dec;
        out_cycles <= next_dec.two_step ? fused_cycles : 4'h1;
      end
    end
  end

  // APB decode. The slave answers in the access cycle with no wait states.
  wire logic apb_acc = psel && penable;
  wire logic hit_ctrl = paddr == REG_CTRL;
  wire logic hit_cnt = paddr == REG_COUNT;
  wire logic hit_last = paddr == REG_LAST_ILL;
  wire logic apb_miss = !(hit_ctrl || hit_cnt || hit_last);
  wire logic wr_ctrl = apb_acc && pwrite && hit_ctrl;
  wire logic clr_req = wr_ctrl && pwdata[CTRL_CLR_BIT];
  assign pready = 1'b1;
  assign pslverr = apb_acc && apb_miss;

  // Counters of claimed words and of traps, cleared by a control write with the clear bit set.
  logic [CNT_W-1:0] dec_cnt;
  logic [CNT_W-1:0] ill_cnt;
  logic [31:0] last_ill;
  wire logic ev_dec = in_fire && next_claim;
  wire logic ev_ill = in_fire && next_ill;

  // Control register; the variant bit resets to the built variant.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_en <= EXT_VARIANT;
    end else if (wr_ctrl) begin
      ext_en <= pwdata[CTRL_EXT_BIT] && EXT_VARIANT;
    end
  end

  // An event in the clearing cycle still counts once, so none is lost.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_cnt <= '0;
      ill_cnt <= '0;
      last_ill <= 32'h0000_0000;
    end else begin
      dec_cnt <= (clr_req ? '0 : dec_cnt) + CNT_W'(ev_dec);
      ill_cnt <= (clr_req ? '0 : ill_cnt) + CNT_W'(ev_ill);
      if (ev_ill) begin
        last_ill <= in_instr;
      end
    end
  end

  // Read data is combinational from the registers; unmapped reads give zero.
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata[CTRL_EXT_BIT] = ext_en;
    end else if (hit_cnt) begin
      prdata = {ill_cnt, dec_cnt};
    end else if (hit_last) begin
      prdata = last_ill;
    end
  end

  // Checks beside the logic they guard.
  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_stall_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_dec)) else $error("output changed during stall");
  chk_fused_decode: assert property (in_fire && in_instr[31:26] == 6'h01 &&
    ext_en |=> out_dec.two_step && out_cycles == fused_cycles)
    else $error("primary one not decoded as fused branch");
  chk_base_traps: assert property (in_fire && !ext_en && in_instr[31:26] == 6'h07
    |=> out_valid && out_dec.illegal) else $error("extended opcode ran on base variant");
  chk_dd_xo: assert property (in_fire && in_instr[31:26] == 6'h3E &&
    in_instr[1:0] != 2'h3 |=> out_dec.illegal) else $error("bad stack opcode accepted");
  chk_dd_disp: assert property (in_fire && ext_en && in_instr[31:26] == 6'h3A &&
    in_instr[1:0] == 2'h3 && in_instr[25:21] == in_instr[20:16] &&
    GPR_DEFINED[in_instr[20:16]] |=> !out_dec.illegal &&
    out_dec.imm == {{16{$past(in_instr[15])}}, $past(in_instr[15:3]), 3'h0})
    else $error("stack displacement wrong");
  chk_target_align: assert property (out_valid |-> out_dec.target[1:0] == 2'h0)
    else $error("unaligned branch target");
  chk_ctx_count: assert property (out_valid && out_dec.context_save_select
    |-> out_dec.acc_cnt == 4'hA) else $error("context frame count wrong");
  chk_rot_unbuilt: assert property (in_fire && in_instr[31:26] == 6'h1E &&
    in_instr[4:2] == 3'h2 |=> out_dec.illegal) else $error("unbuilt rotate decoded");
  chk_reg_trap: assert property (in_fire && in_instr[31:26] == 6'h05 &&
    !GPR_DEFINED[in_instr[20:16]] |=> out_dec.illegal) else $error("undefined register");
  chk_clear_wins: assert property (clr_req && !ev_ill |=> ill_cnt == '0)
    else $error("trap counter not cleared");

  // Decode checks for the added families; all but chk_shamt_word and chk_same_reg look at the word one cycle after it is taken.
  chk_mul_imm: assert property (in_fire && ext_en && !bad_reg &&
    f_po == PO_MUL_IMM
    |=> out_dec.op == OP_MUL_IMM)
    else $error("immediate multiply not decoded");
  chk_rot_insert: assert property (in_fire && ext_en && !bad_reg &&
    f_po == PO_ROT64 && f_md == MD_INSERT
    |=> out_dec.op == OP_ROT_INS)
    else $error("rotate insert not decoded");
  chk_vd_disp: assert property (in_fire && !bad_reg && f_po == PO_VD_LDU
    |=> out_dec.op == OP_VD_LDU &&
    out_dec.imm == {{16{$past(in_instr[15])}}, $past(in_instr[15:0])})
    else $error("doubleword displacement wrong");
  chk_vd_store: assert property (in_fire && !bad_reg &&
    f_po == PO_VD_STU
    |=> out_dec.op == OP_VD_STU)
    else $error("doubleword store with update not decoded");
  chk_dc_query: assert property (in_fire && !bad_reg &&
    f_po == PO_XFORM && f_xo == XO_DC_QUERY
    |=> out_dec.op == OP_DC_QUERY)
    else $error("cache query not decoded");
  chk_fused_kind: assert property (in_fire && !bad_reg && f_po == PO_FUSED &&
    fused_cmp_ext_opcode == FC_UNSIGNED
    |=> out_dec.op == OP_CB_UNSIGNED)
    else $error("unsigned fused compare not decoded");
  chk_bit_kind: assert property (in_fire && !bad_reg && f_po == PO_FUSED &&
    fused_cmp_ext_opcode == FC_BIT
    |=> out_dec.op == ($past(in_instr[22]) ? OP_CB_CLRBIT : OP_CB_BIT))
    else $error("bit branch kind wrong");
  chk_stk_pop: assert property (in_fire && ext_en && !bad_reg && f_po == PO_STK_POP &&
    f_dd_xo == DD_XO && f_rt == f_ra
    |=> out_dec.op == OP_STK_POP && out_dec.sp_writeback)
    else $error("stack pop not decoded");
  chk_shamt_word: assert property (out_valid &&
    out_dec.op inside {OP_SHL_VD, OP_SHR_VD}
    |-> out_dec.shamt_word)
    else $error("shift amount not from a word");
  chk_reserved_rc: assert property (in_fire && ext_en && !bad_reg &&
    f_po == PO_XFORM && in_instr[0]
    |=> !out_dec.illegal)
    else $error("reserved bit caused a trap");
  chk_polarity: assert property (in_fire &&
    f_po == PO_FUSED
    |=> out_dec.branch_polarity == $past(in_instr[23]))
    else $error("branch polarity wrong");
  chk_bit_mask: assert property (in_fire &&
    f_po == PO_FUSED
    |=> out_dec.bit_mask == 32'h8000_0000 >> $past(in_instr[15:11]))
    else $error("bit number not big-endian");
  chk_link_bit: assert property (in_fire &&
    f_po == PO_FUSED
    |=> out_dec.link == $past(in_instr[0]))
    else $error("link bit wrong");
  chk_same_reg: assert property (out_valid &&
    out_dec.sp_writeback && !out_dec.illegal
    |-> out_dec.rt == out_dec.ra)
    else $error("stack registers differ");
  chk_vd_load: assert property (in_fire && !bad_reg &&
    f_po == PO_VD_LD
    |=> out_dec.op == OP_VD_LD)
    else $error("primary opcode misread");

  cov_fused: cover property (in_fire && in_instr[31:26] == 6'h01 ##1 out_dec.link);
  cov_push: cover property (out_valid && out_dec.op == OP_STK_PUSH);
  cov_trap: cover property (out_valid && out_dec.illegal);
  cov_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  cov_ctx: cover property (out_valid && out_dec.context_save_select);

endmodule

//--- dv/xod_exec_model.sv
// Execute-stage stand-in that takes decoded words from the decoder.
`timescale 1ns/100ps
module xod_exec_model
  import xod_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Decode stream from the decoder.
  input wire logic out_valid,
  input wire xod_dec_t out_dec,
  output logic out_ready,
  // Bench control and capture.
  input wire logic stall,
  output logic took,
  output xod_dec_t took_dec
);
  // Stalling holds the decode on the port, so the bench can watch it stand.
  assign out_ready = !stall;
  // One capture per handover edge; a stale capture is never flagged as new.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      took <= 1'b0;
      took_dec <= '0;
    end else begin
      took <= out_valid && out_ready;
      took_dec <= out_dec;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the extended opcode decoder.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module testbench
  import xod_pkg::*;
;
  typedef struct packed {logic [31:0] w; xod_op_t op; logic ill;} xod_row_t;
  logic clk, resetn, in_valid, in_ready, out_valid, out_ready, stall, took;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] in_instr, in_pc, pwdata, prdata, rd;
  logic [11:0] paddr;
  logic [3:0] out_cycles;
  xod_dec_t out_dec, took_dec, d;
  xod_row_t rows[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // Register 31 is left undefined so the undefined-register trap can be reached.
  xod_decoder #(.EXT_VARIANT(1'b1), .GPR_DEFINED(32'h7FFF_FFFF), .CMP_CYCLES(1),
    .BR_CYCLES(1)) u_dut (.clk(clk), .resetn(resetn), .in_valid(in_valid),
    .in_ready(in_ready), .in_instr(in_instr), .in_pc(in_pc), .out_valid(out_valid),
    .out_ready(out_ready), .out_dec(out_dec), .out_cycles(out_cycles), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  xod_exec_model u_exec (.clk(clk), .resetn(resetn), .out_valid(out_valid),
    .out_dec(out_dec), .out_ready(out_ready), .stall(stall), .took(took),
    .took_dec(took_dec));
  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Word packers; reserved bits stay zero as a code generator should write them.
  function automatic logic [31:0] fcb(input logic [1:0] k, input logic p,
      input logic [1:0] s, input logic [4:0] rb, input logic [9:0] bd, input logic lk);
    return {6'h01, k, p, s, 5'h03, rb, bd, lk};
  endfunction
  function automatic logic [31:0] xf(input logic [9:0] xo);
    return {6'h1F, 5'h02, 5'h03, 5'h04, xo, 1'b0};
  endfunction
  // Data and base registers are the same register unless a test means otherwise.
  function automatic logic [31:0] dd(input logic [5:0] po, input logic [4:0] rt,
      input logic [12:0] v, input logic cx, input logic [1:0] xo);
    return {po, rt, 5'h01, v, cx, xo};
  endfunction
  function automatic logic [31:0] di(input logic [5:0] po, input logic [4:0] rt);
    return {po, rt, 5'h03, 16'h0011};
  endfunction
  function automatic logic [31:0] md(input logic [2:0] sub);
    return {6'h1E, 10'h043, 11'h000, sub, 2'h0};
  endfunction
  // Offer one word and return at the edge where it was accepted, valid still high.
  task automatic issue(input logic [31:0] w);
    int n = 0;
    in_valid <= 1'b1;
    in_instr <= w;
    do begin @(posedge clk); n++; end while (in_ready !== 1'b1 && n < 50);
    `CHK("accept", 1'b1, in_ready)
  endtask
  // Released instruction lines show the inverse of the last word, not a stale copy.
  task automatic idle();
    in_valid <= 1'b0;
    in_instr <= ~in_instr;
  endtask
  task automatic take(output xod_dec_t q);
    int n = 0;
    do begin @(posedge clk); n++; end while (took !== 1'b1 && n < 50);
    `CHK("take", 1'b1, took)
    q = took_dec;
  endtask
  task automatic run(input logic [31:0] w);
    issue(w);
    idle();
    take(d);
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A hang is cut short well after the couple of hundred cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    resetn = 1'b0;
    {in_valid, stall, psel, penable, pwrite} = '0;
    {in_instr, in_pc, pwdata, paddr} = '0;
    repeat (10) @(posedge clk);
    `CHK("rst valid", 1'b0, out_valid)
    `CHK("rst ready", 1'b1, in_ready)
    `CHK("rst pready", 1'b1, pready)
    resetn <= 1'b1;
    in_pc <= 32'h0000_1002;
    rows.push_back('{di(6'h05, 5'h02), OP_VD_LD, 1'b0});
    rows.push_back('{di(6'h09, 5'h02), OP_VD_LDU, 1'b0});
    rows.push_back('{di(6'h06, 5'h02), OP_VD_ST, 1'b0});
    rows.push_back('{di(6'h16, 5'h02), OP_VD_STU, 1'b0});
    rows.push_back('{xf(10'h196), OP_DC_QUERY, 1'b0});
    rows.push_back('{xf(10'h011), OP_VD_LDX, 1'b0});
    rows.push_back('{xf(10'h091), OP_VD_STX, 1'b0});
    rows.push_back('{fcb(2'h0, 1'b0, 2'h0, 5'h04, 10'h000, 1'b0), OP_CB_SIGNED, 1'b0});
    rows.push_back('{fcb(2'h1, 1'b0, 2'h0, 5'h04, 10'h000, 1'b0), OP_CB_UNSIGNED, 1'b0});
    rows.push_back('{fcb(2'h2, 1'b0, 2'h0, 5'h04, 10'h000, 1'b0), OP_CB_IMM, 1'b0});
    rows.push_back('{fcb(2'h3, 1'b0, 2'h0, 5'h04, 10'h000, 1'b0), OP_CB_BIT, 1'b0});
    rows.push_back('{fcb(2'h3, 1'b0, 2'h2, 5'h04, 10'h000, 1'b0), OP_CB_CLRBIT, 1'b0});
    rows.push_back('{dd(6'h3A, 5'h01, 13'h0008, 1'b0, 2'h3), OP_STK_POP, 1'b0});
    rows.push_back('{dd(6'h3E, 5'h01, 13'h0008, 1'b0, 2'h3), OP_STK_PUSH, 1'b0});
    rows.push_back('{xf(10'h03B), OP_SHL_VD, 1'b0});
    rows.push_back('{xf(10'h23B), OP_SHR_VD, 1'b0});
    rows.push_back('{di(6'h07, 5'h02), OP_MUL_IMM, 1'b0});
    rows.push_back('{xf(10'h0EB), OP_MUL_REG, 1'b0});
    rows.push_back('{md(3'h3), OP_ROT_INS, 1'b0});
    rows.push_back('{md(3'h1), OP_ROT_CR, 1'b0});
    rows.push_back('{md(3'h0), OP_ROT_CL, 1'b0});
    rows.push_back('{md(3'h2), OP_NONE, 1'b1});
    rows.push_back('{md(3'h4), OP_NONE, 1'b1});
    rows.push_back('{dd(6'h3A, 5'h01, 13'h0008, 1'b0, 2'h1), OP_NONE, 1'b1});
    rows.push_back('{dd(6'h3E, 5'h02, 13'h0008, 1'b0, 2'h3), OP_NONE, 1'b1});
    rows.push_back('{di(6'h05, 5'h1F), OP_NONE, 1'b1});
    rows.push_back('{di(6'h05, 5'h02) | 32'h001F_0000, OP_NONE, 1'b1});
    rows.push_back('{xf(10'h011) | 32'h0000_0001, OP_VD_LDX, 1'b0});
    rows.push_back('{di(6'h0E, 5'h02), OP_NONE, 1'b0});
    foreach (rows[i]) begin
      run(rows[i].w);
      `CHK("op", rows[i].op, d.op)
      `CHK("illegal", rows[i].ill, d.illegal)
    end
    // Fused branch backwards with link; the low pc bits must not leak into the target.
    run(fcb(2'h0, 1'b1, 2'h2, 5'h04, 10'h3FF, 1'b1));
    `CHK("target", 32'h0000_0FFC, d.target)
    `CHK("link", 1'b1, d.link)
    `CHK("polarity", 1'b1, d.branch_polarity)
    `CHK("selector", 2'h2, d.cond_bit_select)
    `CHK("rb", 5'h04, d.rb)
    // The bench sees the handover one edge late, so out_cycles is read from the port.
    `CHK("cycles", 4'h2, out_cycles)
    run(fcb(2'h3, 1'b0, 2'h1, 5'h05, 10'h004, 1'b0));
    `CHK("bit mask", 32'h0400_0000, d.bit_mask)
    `CHK("bit src", 1'b0, d.bit_from_reg)
    `CHK("fwd target", 32'h0000_1010, d.target)
    run(dd(6'h3E, 5'h01, 13'h1FFF, 1'b1, 2'h3));
    `CHK("dd imm", 32'hFFFF_FFF8, d.imm)
    `CHK("ctx cnt", 4'hA, d.acc_cnt)
    `CHK("ctx", 1'b1, d.context_save_select)
    `CHK("sp wb", 1'b1, d.sp_writeback)
    run(xf(10'h03B));
    `CHK("shamt", 1'b1, d.shamt_word)
    // Stalled execute: the second word is refused while the first stands.
    stall <= 1'b1;
    issue(xf(10'h011));
    in_instr <= xf(10'h091);
    repeat (4) begin
      @(posedge clk);
      `CHK("refused", 1'b0, in_ready)
      `CHK("stands", OP_VD_LDX, out_dec.op)
    end
    stall <= 1'b0;
    issue(xf(10'h091));
    idle();
    take(d);
    `CHK("first", OP_VD_LDX, d.op)
    take(d);
    `CHK("second", OP_VD_STX, d.op)
    // Registers: counters, last trap, base-variant trapping and an unmapped word.
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl rst", 32'h0000_0001, rd)
    apb(1'b1, 12'h000, 32'h0000_0003);
    run(dd(6'h3A, 5'h01, 13'h0000, 1'b0, 2'h2));
    apb(1'b0, 12'h004, 32'h0);
    `CHK("count", 32'h0001_0001, rd)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("last", dd(6'h3A, 5'h01, 13'h0000, 1'b0, 2'h2), rd)
    apb(1'b1, 12'h000, 32'h0);
    run(di(6'h07, 5'h02));
    `CHK("base mul", 1'b1, d.illegal)
    run(xf(10'h23B));
    `CHK("base shift", 1'b1, d.illegal)
    run(di(6'h05, 5'h02));
    `CHK("base load", OP_VD_LD, d.op)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    // A mid-run reset must restore the built variant and empty the counters.
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    `CHK("rst2 valid", 1'b0, out_valid)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("rst2 ctrl", 32'h0000_0001, rd)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("rst2 count", 32'h0, rd)
    close_out();
  end
endmodule
